// ---- logic/mmt_pkg.sv ----
/*
  Register map, field positions, reset values and rate codes of the motor mode timer.
  Assumes a 32-bit classic Wishbone slave, one register per aligned word.
*/
package mmt_pkg;
  localparam logic [4:0] ADDR_RUN_RESET_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS_CAPTURE = 5'h04;
  localparam logic [4:0] ADDR_INTERVAL_CAP   = 5'h08;
  localparam logic [4:0] ADDR_COMMUT_CMP     = 5'h0C;
  localparam logic [4:0] ADDR_DETSTART_CMP   = 5'h10;
  localparam logic [4:0] ADDR_OVERFLOW_CMP   = 5'h14;
  localparam logic [4:0] ADDR_MODE_TIMER     = 5'h18;

  localparam int BIT_RUN_ENABLE      = 0;
  localparam int BIT_DETECT_RESET    = 1;
  localparam int BIT_SW_RESET        = 2;
  localparam int BIT_OVERLOAD_RESET  = 3;
  localparam int BIT_T3_RESET        = 4;
  localparam int POS_RATE_SELECT     = 5;
  localparam int BIT_DETECT_CAPTURE  = 1;
  localparam int BIT_SW_CAPTURE      = 2;
  localparam int BIT_OVERLOAD_CAPTURE = 3;
  localparam int BIT_OVERFLOW_FLAG   = 5;
  localparam int BIT_DEBUG_OUT       = 7;

  localparam logic [7:0]  RESET_CTRL  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [15:0] TIMER_MAX   = 16'hFFFF;

  localparam logic [2:0] RATE_DIV8   = 3'h0;
  localparam logic [2:0] RATE_DIV16  = 3'h2;
  localparam logic [2:0] RATE_DIV32  = 3'h4;
  localparam logic [2:0] RATE_DIV64  = 3'h6;
  localparam logic [2:0] RATE_DIV128 = 3'h1;
endpackage

// ---- logic/mmt_mode_timer.sv ----
/*
  Motor mode timer: 16-bit up counter with reset and capture sources and three one-shot
  compare timers, reached over a classic Wishbone slave.
  Assumes positionFound and overloadTrip come from other clock domains or pins and are
  synchronised here; events are taken on their rising edge.
*/
`timescale 1ns/1ps
module mmt_mode_timer
  import mmt_pkg::*;
#(
  parameter int TW = 16
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clkEn,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [4:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          positionFound,
  input  wire logic          overloadTrip,
  output logic               commutation_irq,
  output logic               detect_start_irq,
  output logic               overflow_irq,
  output logic               debugPin
);

  // Control and status storage
  logic [7:0]    runResetCtrl;
  logic [7:0]    statusCapCtrl;
  logic          overflowFlag;
  logic [TW-1:0] modeTimer;
  logic [TW-1:0] intervalCapture;
  logic [TW-1:0] cmpValue [3];
  logic [2:0]    armed;
  logic [2:0]    fire;
  logic [7:0]    prescale;
  logic [1:0]    posSync;
  logic [1:0]    ovlSync;
  logic          posLast;
  logic          ovlLast;
  logic          swResetPulse;
  logic          swCapturePulse;

  wire logic busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire logic busRead  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic runEn    = runResetCtrl[BIT_RUN_ENABLE];
  wire logic posEvent = posSync[1] & ~posLast;
  wire logic ovlEvent = ovlSync[1] & ~ovlLast;

  function automatic logic isWrite(input logic [4:0] adr, input logic [4:0] target);
    return busWrite && (adr == target);
  endfunction

  // Division ratio per rate code; reserved codes fall back to the slowest rate
  function automatic logic [7:0] rateMask(input logic [2:0] sel);
    unique case (sel)
      RATE_DIV8:   rateMask = 8'h07;
      RATE_DIV16:  rateMask = 8'h0F;
      RATE_DIV32:  rateMask = 8'h1F;
      RATE_DIV64:  rateMask = 8'h3F;
      default:     rateMask = 8'h7F;
    endcase
  endfunction

  // Two-stage synchronisers for the external event lines
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      posSync <= 2'h0;
      ovlSync <= 2'h0;
      posLast <= 1'b0;
      ovlLast <= 1'b0;
    end else if (clkEn) begin
      posSync <= {posSync[0], positionFound};
      ovlSync <= {ovlSync[0], overloadTrip};
      posLast <= posSync[1];
      ovlLast <= ovlSync[1];
    end
  end

  // Control registers; strobe bits never stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runResetCtrl  <= RESET_CTRL;
      statusCapCtrl <= RESET_CTRL;
    end else if (clkEn) begin
      if (isWrite(wb_adr_i, ADDR_RUN_RESET_CTRL))
        runResetCtrl <= wb_dat_i[7:0] & ~(8'h01 << BIT_SW_RESET);
      if (isWrite(wb_adr_i, ADDR_STATUS_CAPTURE))
        statusCapCtrl <= wb_dat_i[7:0] & 8'h8A;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swResetPulse   <= 1'b0;
      swCapturePulse <= 1'b0;
    end else if (clkEn) begin
      swResetPulse   <= isWrite(wb_adr_i, ADDR_RUN_RESET_CTRL) && wb_dat_i[BIT_SW_RESET];
      swCapturePulse <= isWrite(wb_adr_i, ADDR_STATUS_CAPTURE) && wb_dat_i[BIT_SW_CAPTURE];
    end
  end

  // Hardware and software clear sources
  // detect reset
  wire logic posClear = posEvent & runResetCtrl[BIT_DETECT_RESET];
  wire logic ovlClear = ovlEvent & runResetCtrl[BIT_OVERLOAD_RESET];
  wire logic t3Clear  = fire[2] & runResetCtrl[BIT_T3_RESET];
  wire logic anyClear = posClear | ovlClear | t3Clear | swResetPulse;

  wire logic tick = runEn && ((prescale & rateMask(runResetCtrl[7:POS_RATE_SELECT])) == 8'h00);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= 8'h00;
    end else if (clkEn) begin
      prescale <= runEn ? prescale + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeTimer    <= TW'(RESET_WORD);
      overflowFlag <= 1'b0;
    end else if (clkEn) begin
      if (anyClear) begin
        modeTimer <= '0;
      end else if (tick && modeTimer != TW'(TIMER_MAX)) begin
        modeTimer <= modeTimer + 1'b1;
      end
      // sticky overflow; a reset restarts the count
      if (tick && !anyClear && modeTimer == TW'(TIMER_MAX - 16'h0001))
        overflowFlag <= 1'b1;
      else if (anyClear)
        overflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intervalCapture <= TW'(RESET_WORD);
    end else if (clkEn) begin
      if ((posEvent && statusCapCtrl[BIT_DETECT_CAPTURE]) ||
          (ovlEvent && statusCapCtrl[BIT_OVERLOAD_CAPTURE]) || swCapturePulse)
        intervalCapture <= modeTimer;
    end
  end

  // stop detection; only a falling run enable cancels, so compares
  // loaded while stopped survive until the timer is started
  logic runWas;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runWas <= 1'b0;
    end else if (clkEn) begin
      runWas <= runEn;
    end
  end

  wire logic runStopped = runWas & ~runEn;

  always_comb begin
    fire[0] = runEn && armed[0] && (modeTimer >= cmpValue[0]);
    fire[1] = runEn && armed[1] && (modeTimer == cmpValue[1]);
    fire[2] = runEn && armed[2] && (modeTimer == cmpValue[2]);
  end

  genvar g;
  for (g = 0; g < 3; g++) begin : gCmp
    localparam logic [4:0] ADR = ADDR_COMMUT_CMP + 5'(4 * g);
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmpValue[g] <= TW'(RESET_WORD);
        armed[g]    <= 1'b0;
      end else if (clkEn) begin
        if (isWrite(wb_adr_i, ADR)) begin
          cmpValue[g] <= wb_dat_i[TW-1:0];
          armed[g]    <= 1'b1;
        end else if (fire[g] || anyClear || runStopped) begin
          armed[g]    <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      commutation_irq  <= 1'b0;
      detect_start_irq <= 1'b0;
      overflow_irq     <= 1'b0;
      debugPin         <= 1'b0;
    end else if (clkEn) begin
      commutation_irq  <= fire[0];
      detect_start_irq <= fire[1];
      overflow_irq     <= fire[2];
      debugPin         <= statusCapCtrl[BIT_DEBUG_OUT] & (|fire);
    end
  end

  // Wishbone answer: one registered ack cycle after one wait state, unmapped reads return zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      wb_ack_o <= busRead;
      if (busRead) begin
        unique case (wb_adr_i)
          ADDR_RUN_RESET_CTRL: wb_dat_o <= {24'h0, runResetCtrl};
          ADDR_STATUS_CAPTURE: wb_dat_o <= {24'h0, statusCapCtrl |
                                            (8'(overflowFlag) << BIT_OVERFLOW_FLAG)};
          ADDR_INTERVAL_CAP:   wb_dat_o <= 32'(intervalCapture);
          ADDR_COMMUT_CMP:     wb_dat_o <= 32'(cmpValue[0]);
          ADDR_DETSTART_CMP:   wb_dat_o <= 32'(cmpValue[1]);
          ADDR_OVERFLOW_CMP:   wb_dat_o <= 32'(cmpValue[2]);
          ADDR_MODE_TIMER:     wb_dat_o <= 32'(modeTimer);
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  a_clear_zeroes_timer: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && anyClear |=> modeTimer == '0)
    else $error("timer not cleared");
  a_saturate_at_max: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && modeTimer == TW'(TIMER_MAX) && !anyClear |=> modeTimer == TW'(TIMER_MAX))
    else $error("timer passed max");
  a_overflow_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && modeTimer == TW'(TIMER_MAX) && !anyClear |=> overflowFlag)
    else $error("overflow flag missing");
  a_one_shot_fire: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && fire[0] && !isWrite(wb_adr_i, ADDR_COMMUT_CMP) |=> !armed[0])
    else $error("compare stayed armed");
  a_no_fire_stopped: assert property (@(posedge clk) disable iff (!reset_n)
    !runEn |-> fire == 3'h0)
    else $error("fire while stopped");
  a_irq_follows_fire: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && fire[1] |=> detect_start_irq)
    else $error("irq missing");
  a_cap_on_detect: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && posEvent && statusCapCtrl[BIT_DETECT_CAPTURE] |=> intervalCapture == $past(modeTimer))
    else $error("capture wrong");
  a_stop_cancels_cmp: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && runStopped && !busWrite |=> armed == 3'h0)
    else $error("compare survived stop");

  a_detect_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && posEvent && runResetCtrl[BIT_DETECT_RESET] |=> modeTimer == '0)
    else $error("detect reset missed");

  a_overload_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && ovlEvent && runResetCtrl[BIT_OVERLOAD_RESET] |=> modeTimer == '0)
    else $error("overload reset missed");

  a_t3_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && fire[2] && runResetCtrl[BIT_T3_RESET] |=> modeTimer == '0)
    else $error("timer3 reset missed");

  a_count_on_tick: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && tick && !anyClear && modeTimer != TW'(TIMER_MAX)
    |=> modeTimer == $past(modeTimer) + 1'b1)
    else $error("count step wrong");

  a_hold_no_tick: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !tick && !anyClear |=> modeTimer == $past(modeTimer))
    else $error("timer moved without tick");

  a_cap_on_overload: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && ovlEvent && statusCapCtrl[BIT_OVERLOAD_CAPTURE]
    |=> intervalCapture == $past(modeTimer))
    else $error("overload capture wrong");

  a_cap_on_software: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && swCapturePulse |=> intervalCapture == $past(modeTimer))
    else $error("software capture wrong");

  a_cap_holds: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !posEvent && !ovlEvent && !swCapturePulse |=> $stable(intervalCapture))
    else $error("capture changed");

  a_strobes_not_kept: assert property (@(posedge clk) disable iff (!reset_n)
    !runResetCtrl[BIT_SW_RESET] && !statusCapCtrl[BIT_SW_CAPTURE])
    else $error("strobe bit stored");

  a_sw_reset_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && isWrite(wb_adr_i, ADDR_RUN_RESET_CTRL) && wb_dat_i[BIT_SW_RESET]
    |=> swResetPulse)
    else $error("reset strobe lost");

  a_commut_magnitude: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && runEn && armed[0] && modeTimer >= cmpValue[0] |=> commutation_irq)
    else $error("commutation missed");

  a_detect_exact: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && modeTimer != cmpValue[1] |=> !detect_start_irq)
    else $error("detect start off equality");

  a_overflow_irq: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && fire[2] |=> overflow_irq)
    else $error("overflow irq missing");

  a_t3_once: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && fire[2] && !isWrite(wb_adr_i, ADDR_OVERFLOW_CMP) |=> !fire[2])
    else $error("timer3 fired twice");

  a_debug_output: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && statusCapCtrl[BIT_DEBUG_OUT] && (|fire) |=> debugPin)
    else $error("debug pin missing");

  a_debug_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !statusCapCtrl[BIT_DEBUG_OUT] |=> !debugPin)
    else $error("debug pin while disabled");

  a_overflow_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && overflowFlag && !anyClear |=> overflowFlag)
    else $error("overflow flag lost");

  a_prescale_parked: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && !runEn |=> prescale == 8'h00)
    else $error("prescaler ran while stopped");

  // Single-cycle bus answer
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  c_commutation: cover property (@(posedge clk) commutation_irq);
  c_detect_clear: cover property (@(posedge clk) posClear);
  c_t3_clear: cover property (@(posedge clk) t3Clear);
  c_overflow: cover property (@(posedge clk) overflowFlag);
  c_capture: cover property (@(posedge clk) swCapturePulse);

endmodule

// ---- bench/mmt_event_model.sv ----
/*
  Far-side model: the position detection and overload protection circuits.
  Assumes the timer synchronises both lines and reacts to their rising edge.
*/
`timescale 1ns/1ps
module mmt_event_model (
  input  wire logic clk,
  output logic      positionFound,
  output logic      overloadTrip
);
  initial begin
    positionFound = 1'b0;
    overloadTrip  = 1'b0;
  end
  // Held 4 clocks so the two-stage synchroniser cannot miss the edge
  task automatic fire(input logic ovl);
    @(posedge clk);
    if (ovl) overloadTrip <= 1'b1;
    else positionFound <= 1'b1;
    repeat (4) @(posedge clk);
    overloadTrip  <= 1'b0;
    positionFound <= 1'b0;
  endtask
endmodule

// ---- bench/test_motor_mode_timer_capture.sv ----
/*
  Self-checking bench of the motor mode timer over classic Wishbone.
  Assumes the event model drives the position and overload lines.
*/
`timescale 1ns/1ps
module test_motor_mode_timer_capture;
  import mmt_pkg::*;
  localparam logic [4:0] aCtl = ADDR_RUN_RESET_CTRL;
  localparam logic [4:0] aSts = ADDR_STATUS_CAPTURE;
  localparam logic [4:0] aCap = ADDR_INTERVAL_CAP;
  localparam logic [4:0] aTmr = ADDR_MODE_TIMER;
  logic        clk, reset_n, cyc, stb, we, ack, i1, i2, i3, dbg, pf, ot;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat;
  int          error_cnt = 0, checks = 0, n1 = 0, n2 = 0, n3 = 0, nd = 0;

  mmt_mode_timer i_mmt_mode_timer (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .positionFound(pf),
    .overloadTrip(ot), .commutation_irq(i1), .detect_start_irq(i2),
    .overflow_irq(i3), .debugPin(dbg));
  mmt_event_model i_mmt_event_model (.clk(clk), .positionFound(pf), .overloadTrip(ot));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n1 += (i1 === 1'b1);
    n2 += (i2 === 1'b1);
    n3 += (i3 === 1'b1);
    nd += (dbg === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      final_report;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    rd(aCtl, q); chk(q, 32'h0);
    rd(5'h1C, q); chk(q, 32'h0);
    wr(aSts, 32'hFF); rd(aSts, q); chk(q, 32'h8A);
    wr(aCtl, 32'hFE); rd(aCtl, q); chk(q, 32'hFA);
    wr(aCap, 32'h1234); rd(aCap, q); chk(q, 32'h0);
    wr(aCtl, 32'h0);
    wr(aSts, 32'h0);
    $display("registers done");
  endtask

  task automatic t_rate;
    logic [31:0] q;
    logic [2:0]  c [5] = '{RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64, RATE_DIV128};
    for (int i = 0; i < 5; i++) begin
      // Rate is changed only while stopped
      wr(aCtl, {24'h0, c[i], 5'h00});
      wr(aCtl, {24'h0, c[i], 5'h05});
      repeat (1024) @(posedge clk);
      rd(aTmr, q);
      ok(q + 1 >= 1024 / (8 << i) && q <= 1024 / (8 << i) + 2);
      wr(aCtl, {24'h0, c[i], 5'h00});
    end
    $display("rates done");
  endtask

  task automatic t_event(input logic ovl);
    logic [31:0] c0, c1, t;
    logic [7:0]  en;
    en = ovl ? 8'h08 : 8'h02;
    wr(aCtl, 32'h5);
    repeat (200) @(posedge clk);
    rd(aCap, c0);
    i_mmt_event_model.fire(ovl);
    repeat (10) @(posedge clk);
    rd(aTmr, t); ok(t > 20);
    rd(aCap, c1); chk(c1, c0);
    wr(aCtl, {24'h0, en | 8'h05});
    wr(aSts, {24'h0, en});
    repeat (200) @(posedge clk);
    i_mmt_event_model.fire(ovl);
    repeat (10) @(posedge clk);
    rd(aTmr, t); ok(t < 8);
    rd(aCap, c1); ok(c1 > 20 && c1 < 40);
    wr(aCtl, 32'h0);
    wr(aSts, 32'h0);
    $display("event test done");
  endtask

  task automatic t_sw;
    logic [31:0] c, t;
    wr(aCtl, 32'h5);
    repeat (400) @(posedge clk);
    wr(aSts, 32'h4);
    rd(aCap, c);
    rd(aTmr, t); ok(c > 40 && c <= t);
    rd(aSts, c); chk(c, 32'h0);
    wr(aCtl, 32'h1);
    rd(aTmr, t); ok(t > 40);
    wr(aCtl, 32'h5);
    rd(aTmr, t); ok(t < 4);
    $display("software ops done");
  endtask

  task automatic t_cmp;
    logic [31:0] t, t2;
    int m1, m2, m3, md;
    wr(aCtl, 32'h11);
    wr(aSts, 32'h80);
    repeat (200) @(posedge clk);
    // Compares are loaded only while stopped
    wr(aCtl, 32'h10);
    rd(aTmr, t);
    m1 = n1; m2 = n2; m3 = n3; md = nd;
    wr(ADDR_COMMUT_CMP, 32'h5);
    wr(ADDR_DETSTART_CMP, t + 6);
    wr(ADDR_OVERFLOW_CMP, t + 10);
    wr(aCtl, 32'h11);
    repeat (150) @(posedge clk);
    chk(n1 - m1, 1);
    chk(n2 - m2, 1);
    chk(n3 - m3, 1);
    chk(nd - md, 3);
    rd(aTmr, t2); ok(t2 < t + 10);
    // Stopping must cancel an armed compare
    m1 = n1; m2 = n2;
    wr(aCtl, 32'h10);
    rd(aTmr, t);
    wr(ADDR_COMMUT_CMP, t + 8);
    wr(aCtl, 32'h11);
    wr(aCtl, 32'h10);
    wr(ADDR_DETSTART_CMP, 32'h1);
    wr(aCtl, 32'h11);
    repeat (200) @(posedge clk);
    chk(n2 - m2, 0);
    chk(n1 - m1, 0);
    $display("compare test done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 5'h00; sel = 4'h0; dat = 32'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_rate;
    t_event(1'b0);
    t_event(1'b1);
    t_sw;
    t_cmp;
    final_report;
  end
  initial begin
    #500000;
    error_cnt++;
    final_report;
  end
endmodule
